//--- brs_board_reset_supervisor.sv
// board reset supervisor: watchdog, manual and power reset, cause record, remote pn reset
// assumes an apb master on pclk; all board pins are asynchronous and are synchronised here
//
// Behaviour
// - board reset when the watchdog location goes one second without access
// - watchdog jumper disables the watchdog; then it never resets
// - pushbutton or debug contacts reset after debounce, held 250 ms after the debounced release
// - reset held while supply is bad and 250 ms after it is good
// - cause of last reset readable as four bits: power, manual, watchdog, remote
// - serial data of radio port d is searched continuously for a 255-bit pattern
// - selector jumper picks one of twelve pn sequences
// - timing recovery gives nrz or nrzi bits, or is bypassed entirely
// - selector chooses recovered bit clock or modem clock for the search in nrz and nrzi; both bypass settings always use the modem clock
// - remote reset path works with no software or serial controller
// - detection raises nmi when the nmi jumper allows it
// - hard reset if software does not answer the detection within one second
`timescale 1ns/1ps
module brs_board_reset_supervisor #(
    parameter int unsigned WDOG_LIMIT = brs_pkg::WDOG_CYCLES,
    parameter int unsigned HOLD_LIMIT = brs_pkg::HOLD_CYCLES,
    parameter int unsigned DEBOUNCE_LIMIT = brs_pkg::DEBOUNCE_CYCLES,
    parameter int unsigned REMOTE_LIMIT = brs_pkg::REMOTE_CYCLES
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // board reset and interrupts
    input wire logic power_good,
    input wire logic reset_pushbutton_n,
    input wire logic debug_reset_contacts_n,
    output logic board_reset_n,
    output logic nmi,
    output logic irq,
    // configuration jumpers
    input wire logic watchdog_enable_jumper,
    input wire logic nmi_enable_jumper,
    input wire logic detector_clock_select,
    input wire logic [1:0] line_decode_select,
    input wire logic [3:0] pattern_select,
    // radio port d
    input wire logic rx_data,
    input wire logic rx_clk
);
    import brs_pkg::*;

    // synchronisers: every pin passes two flops
    logic [13:0] pin_raw;
    logic [13:0] pin_meta;
    logic [13:0] pin_sync;
    brs_jumper_t jp;
    logic pwr_ok;
    logic contact_closed;
    logic line;
    logic mclk;

    assign pin_raw = {watchdog_enable_jumper, nmi_enable_jumper, detector_clock_select, line_decode_select,
                      pattern_select, power_good, reset_pushbutton_n, debug_reset_contacts_n, rx_data, rx_clk};
    assign jp = brs_jumper_t'(pin_sync[13:5]);
    assign pwr_ok = pin_sync[4];
    assign contact_closed = !pin_sync[3] || !pin_sync[2];
    assign line = pin_sync[1];
    assign mclk = pin_sync[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 14'h0000;
            pin_sync <= 14'h0000;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // apb decode
    logic setup;
    logic access;
    logic wr;
    logic sel_wdog;
    logic sel_cause;
    logic sel_ack;
    logic sel_status;
    logic sel_enable;
    logic sel_clear;
    logic sel_jumpers;
    logic mapped;
    logic kick;
    logic ack;
    logic [3:0] clr;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign sel_wdog = paddr == OFS_WDOG;
    assign sel_cause = paddr == OFS_CAUSE;
    assign sel_ack = paddr == OFS_REMOTE_ACK;
    assign sel_status = paddr == OFS_IRQ_STATUS;
    assign sel_enable = paddr == OFS_IRQ_ENABLE;
    assign sel_clear = paddr == OFS_IRQ_CLEAR;
    assign sel_jumpers = paddr == OFS_JUMPERS;
    assign mapped = sel_wdog || sel_cause || sel_ack || sel_status || sel_enable || sel_clear || sel_jumpers;
    assign kick = access && sel_wdog;
    assign ack = wr && sel_ack && pwdata[0];
    assign clr = (wr && sel_clear) ? pwdata[3:0] : 4'h0;
    assign pready = 1'b1;

    // debounce of the reset contacts
    logic manual_db;
    logic [31:0] db_count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            manual_db <= 1'b0;
            db_count <= 32'h0;
        end else if (contact_closed == manual_db) begin
            db_count <= 32'h0;
        end else if (db_count == 32'(DEBOUNCE_LIMIT - 1)) begin
            manual_db <= contact_closed;
            db_count <= 32'h0;
        end else begin
            db_count <= db_count + 32'h1;
        end
    end

    // watchdog
    logic [31:0] wd_count;
    logic wd_fire;

    assign wd_fire = jp.wdog_en && board_reset_n && !kick && wd_count == 32'(WDOG_LIMIT - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_count <= 32'h0;
        end else if (!jp.wdog_en || !board_reset_n || kick || wd_fire) begin
            wd_count <= 32'h0;
        end else begin
            wd_count <= wd_count + 32'h1;
        end
    end

    // bit timing recovery on the sampled port d line
    logic line_prev;
    logic mclk_prev;
    logic nrzi_ref;
    logic [7:0] phase;
    logic bypass;
    logic rec_strobe;
    logic modem_strobe;
    brs_bit_t bit_out;

    assign bypass = jp.decode == DECODE_BYPASS || jp.decode == DECODE_BYPASS_ALT;
    assign rec_strobe = !bypass && phase == 8'(RECOV_BIT_CYCLES / 2);
    assign modem_strobe = mclk && !mclk_prev;
    // bypass has no local timing, so the modem clock is the only source then
    assign bit_out.strobe = (bypass || jp.clk_sel) ? modem_strobe : rec_strobe;
    assign bit_out.data = (jp.decode == DECODE_NRZI) ? (line == nrzi_ref) : line;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_prev <= 1'b0;
            mclk_prev <= 1'b0;
            nrzi_ref <= 1'b0;
            phase <= 8'h00;
        end else begin
            line_prev <= line;
            mclk_prev <= mclk;
            if (bit_out.strobe) begin
                nrzi_ref <= line;
            end
            if (line != line_prev || phase == 8'(RECOV_BIT_CYCLES - 1)) begin
                phase <= 8'h00;
            end else begin
                phase <= phase + 8'h01;
            end
        end
    end

    logic detect;

    brs_pattern_searcher u_searcher (
        .pclk(pclk),
        .presetn(presetn),
        .bit_in(bit_out),
        .pattern(jp.pattern),
        .detect(detect)
    );

    // remote reset: runs purely in hardware so a crashed processor is still reset
    logic rem_pending;
    logic [31:0] rem_count;
    logic rem_fire;

    assign rem_fire = rem_pending && !detect && rem_count == 32'(REMOTE_LIMIT - 1);
    assign nmi = rem_pending && jp.nmi_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rem_pending <= 1'b0;
            rem_count <= 32'h0;
        end else if (detect) begin
            rem_pending <= 1'b1;
            rem_count <= 32'h0;
        end else if (ack || rem_fire) begin
            rem_pending <= 1'b0;
            rem_count <= 32'h0;
        end else if (rem_pending) begin
            rem_count <= rem_count + 32'h1;
        end
    end

    // reset sequencer and cause record
    logic hold_src;
    logic [31:0] hold_cnt;
    logic [3:0] cause;
    logic [3:0] next_cause;

    assign hold_src = !pwr_ok || manual_db || wd_fire || rem_fire;

    always_comb begin
        next_cause = cause;
        if (!pwr_ok) begin
            next_cause = 4'h0;
            next_cause[CAUSE_POWER] = 1'b1;
        end else if (manual_db) begin
            next_cause = 4'h0;
            next_cause[CAUSE_MANUAL] = 1'b1;
        end else if (wd_fire) begin
            next_cause = 4'h0;
            next_cause[CAUSE_WDOG] = 1'b1;
        end else if (rem_fire) begin
            next_cause = 4'h0;
            next_cause[CAUSE_REMOTE] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt <= 32'(HOLD_LIMIT);
            board_reset_n <= 1'b0;
            cause <= CAUSE_RESET;
        end else begin
            hold_cnt <= hold_src ? 32'(HOLD_LIMIT) : (hold_cnt != 32'h0 ? hold_cnt - 32'h1 : 32'h0);
            board_reset_n <= !hold_src && hold_cnt == 32'h0;
            cause <= next_cause;
        end
    end

    // interrupt status, enable and clear; a new event wins over a clear
    logic [3:0] events;
    logic [3:0] irq_status;
    logic [3:0] irq_enable;
    logic manual_prev;
    logic pwr_prev;

    assign events = {pwr_prev && !pwr_ok, manual_db && !manual_prev, wd_fire, detect};
    assign irq = |(irq_status & irq_enable);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 4'h0;
            irq_enable <= IRQ_ENABLE_RESET;
            manual_prev <= 1'b0;
            pwr_prev <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~clr) | events;
            manual_prev <= manual_db;
            pwr_prev <= pwr_ok;
            if (wr && sel_enable) begin
                irq_enable <= pwdata[3:0];
            end
        end
    end

    // read data captured in the setup cycle, presented in the access cycle
    logic [31:0] rd_mux;

    assign rd_mux = sel_cause ? brs_word4(cause) :
                    sel_status ? brs_word4(irq_status) :
                    sel_enable ? brs_word4(irq_enable) :
                    sel_jumpers ? {23'h0, pin_sync[13:5]} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0 : rd_mux;
            pslverr <= !mapped;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wdog_expiry_a: assert property (
        jp.wdog_en && board_reset_n && !kick && wd_count == 32'(WDOG_LIMIT - 1) |=> !board_reset_n)
        else $error("watchdog expiry did not reset the board");
    wdog_disabled_a: assert property (
        !jp.wdog_en |=> wd_count == 32'h0 && !wd_fire)
        else $error("disabled watchdog kept counting");
    kick_restart_a: assert property (
        kick |=> wd_count == 32'h0)
        else $error("watchdog access did not restart interval");
    manual_reset_a: assert property (
        manual_db |=> !board_reset_n)
        else $error("debounced contact did not reset the board");
    power_hold_a: assert property (
        $fell(hold_src) |-> hold_cnt == 32'(HOLD_LIMIT) ##1 !board_reset_n)
        else $error("hold time not started after source released");
    cause_onehot_a: assert property (
        $onehot(cause) and (wd_fire && pwr_ok && !manual_db |=> cause[CAUSE_WDOG]))
        else $error("reset cause record wrong");
    nmi_gate_a: assert property (
        detect |=> nmi == jp.nmi_en || $changed(jp.nmi_en))
        else $error("nmi not tied to detection and jumper");
    remote_timeout_a: assert property (
        rem_fire |=> !board_reset_n && !rem_pending && cause[CAUSE_REMOTE])
        else $error("remote timeout did not force reset");
    set_wins_a: assert property (
        detect && clr[EV_REMOTE] |=> irq_status[EV_REMOTE])
        else $error("clear beat a simultaneous event");

    wdog_expire_c: cover property (wd_fire);
    remote_detect_c: cover property (detect ##1 nmi);
    manual_press_c: cover property ($rose(manual_db));
    irq_raise_c: cover property ($rose(irq));

endmodule : brs_board_reset_supervisor

//--- brs_pkg.sv
// shared constants, types and helpers of the board reset supervisor
// assumes a single 100 MHz register clock; all pins arrive asynchronously
package brs_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned NS_PER_MS = 1_000_000;

    localparam int unsigned WDOG_TIMEOUT_MS = 1000;
    localparam int unsigned HOLD_TIME_MS = 250;
    localparam int unsigned DEBOUNCE_TIME_MS = 10;
    localparam int unsigned REMOTE_TIMEOUT_MS = 1000;
    localparam int unsigned WDOG_CYCLES = WDOG_TIMEOUT_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned HOLD_CYCLES = HOLD_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned REMOTE_CYCLES = REMOTE_TIMEOUT_MS * NS_PER_MS / CLK_PERIOD_NS;

    // nominal bit period of the local timing recovery
    localparam int unsigned RECOV_BIT_NS = 125;
    localparam int unsigned RECOV_BIT_CYCLES = RECOV_BIT_NS / CLK_PERIOD_NS;

    localparam int unsigned PN_STAGES = 8;
    localparam int unsigned PN_LENGTH = 255;

    // register byte offsets
    localparam logic [7:0] OFS_WDOG = 8'h00;
    localparam logic [7:0] OFS_CAUSE = 8'h04;
    localparam logic [7:0] OFS_REMOTE_ACK = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] OFS_JUMPERS = 8'h18;

    // event bits of status, enable and clear
    localparam int unsigned EV_REMOTE = 0;
    localparam int unsigned EV_WDOG = 1;
    localparam int unsigned EV_MANUAL = 2;
    localparam int unsigned EV_POWER = 3;

    // reset cause bits
    localparam int unsigned CAUSE_POWER = 0;
    localparam int unsigned CAUSE_MANUAL = 1;
    localparam int unsigned CAUSE_WDOG = 2;
    localparam int unsigned CAUSE_REMOTE = 3;

    localparam logic [3:0] CAUSE_RESET = 4'h1;
    localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;

    typedef enum logic [1:0] {
        DECODE_NRZ,
        DECODE_NRZI,
        DECODE_BYPASS,
        DECODE_BYPASS_ALT
    } brs_decode_t;

    typedef struct packed {
        logic strobe;
        logic data;
    } brs_bit_t;

    typedef struct packed {
        logic wdog_en;
        logic nmi_en;
        logic clk_sel;
        brs_decode_t decode;
        logic [3:0] pattern;
    } brs_jumper_t;

    // feedback taps (x^7..x^0) of the twelve supported degree-8 primitive polynomials
    function automatic logic [7:0] brs_taps(input logic [3:0] sel);
        case (sel)
            4'h0: return 8'h1d;
            4'h1: return 8'h2b;
            4'h2: return 8'h2d;
            4'h3: return 8'h4d;
            4'h4: return 8'h5f;
            4'h5: return 8'h63;
            4'h6: return 8'h65;
            4'h7: return 8'h69;
            4'h8: return 8'h71;
            4'h9: return 8'h87;
            4'ha: return 8'h8d;
            4'hb: return 8'ha9;
            default: return 8'h00;
        endcase
    endfunction : brs_taps

    function automatic logic [31:0] brs_word4(input logic [3:0] v);
        return {28'h0, v};
    endfunction : brs_word4

endpackage : brs_pkg

//--- brs_pattern_searcher.sv
// pn pattern searcher: checks the decoded bit stream against one lfsr recurrence
// assumes bit_in arrives on pclk with a one-cycle strobe per bit
`timescale 1ns/1ps
module brs_pattern_searcher (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bit stream
    input brs_pkg::brs_bit_t bit_in,
    input wire logic [3:0] pattern,
    // result
    output logic detect
);
    import brs_pkg::*;

    logic [7:0] hist;
    logic [7:0] run;
    logic [7:0] taps;
    logic [7:0] next_hist;
    logic predicted;
    logic good;
    logic [7:0] next_run;

    assign taps = brs_taps(pattern);
    assign next_hist = {bit_in.data, hist[7:1]};
    assign predicted = ^(hist & taps);
    // any 8 nonzero bits obeying the recurrence are a phase of the m-sequence
    assign good = (bit_in.data == predicted) && (hist != 8'h00);
    assign detect = bit_in.strobe && good && (run == 8'(PN_LENGTH - 1));

    always_comb begin
        next_run = run;
        if (taps == 8'h00 || next_hist == 8'h00) begin
            next_run = 8'h00;
        end else if (run < 8'(PN_STAGES)) begin
            next_run = run + 8'h01;
        end else if (!good) begin
            // the bits just seen may seed a fresh sequence
            next_run = 8'(PN_STAGES);
        end else if (run != 8'hff) begin
            next_run = run + 8'h01;
        end
    end

    // searching never stops and needs no software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist <= 8'h00;
            run <= 8'h00;
        end else if (bit_in.strobe) begin
            hist <= next_hist;
            run <= next_run;
        end
    end

    detect_full_a: assert property (@(posedge pclk) disable iff (!presetn)
        detect |=> run == 8'hff)
        else $error("detect without full 255-bit run");
    detect_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        detect |=> !detect)
        else $error("detect lasted more than one cycle");

endmodule : brs_pattern_searcher

//--- brs_modem_model.sv
// radio modem model for port d: sends a pn frame as nrz, nrzi or clocked bits
// assumes the bench calls send; the link clock only runs inside a frame
`timescale 1ns/1ps
module brs_modem_model (
    // link pins
    output logic rx_clk,
    output logic rx_data
);
    logic lvl;

    initial begin
        rx_clk = 1'b0;
        rx_data = 1'b0;
        lvl = 1'b0;
    end

    // 263 bits: a few beyond one period so a missed first bit still leaves a full window
    task automatic send(input logic [7:0] taps, input logic [7:0] seed, input int flip,
                        input logic nrzi, input logic use_clk);
        logic [7:0] h;
        logic b;
        h = seed;
        #3.7;
        for (int i = 0; i < 263; i++) begin
            b = h[0];
            h = {^(h & taps), h[7:1]};
            if (i == flip) begin
                b = ~b;
            end
            lvl = nrzi ? (b ? lvl : ~lvl) : b;
            rx_data = lvl;
            #62.5;
            rx_clk = use_clk;
            #62.5;
            rx_clk = 1'b0;
        end
        // a released line keeps no last value
        rx_data = ~lvl;
    endtask : send
endmodule : brs_modem_model

//--- brs_board_reset_supervisor_tb_top.sv
// bench of the board reset supervisor: apb master, jumpers, contacts, supply and modem
// assumes shortened counts so the run stays short
`timescale 1ns/1ps
module brs_board_reset_supervisor_tb_top;
    import brs_pkg::*;
    localparam int WL = 200, HL = 20, DL = 8, RL = 600;
    localparam logic [7:0] TAPS [12] = '{8'h1d, 8'h2b, 8'h2d, 8'h4d, 8'h5f, 8'h63,
                                         8'h65, 8'h69, 8'h71, 8'h87, 8'h8d, 8'ha9};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic power_good, pb_n, dbg_n, board_reset_n, nmi, irq;
    logic wd_en, nmi_en, clk_sel, rx_data, rx_clk;
    logic [1:0] dec;
    logic [3:0] pat, v;
    int fails, n_tests, n;
    logic [32:0] exp_q [$];

    brs_board_reset_supervisor #(.WDOG_LIMIT(WL), .HOLD_LIMIT(HL), .DEBOUNCE_LIMIT(DL),
                                 .REMOTE_LIMIT(RL)) dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_good(power_good), .reset_pushbutton_n(pb_n), .debug_reset_contacts_n(dbg_n),
        .board_reset_n(board_reset_n), .nmi(nmi), .irq(irq),
        .watchdog_enable_jumper(wd_en), .nmi_enable_jumper(nmi_en),
        .detector_clock_select(clk_sel), .line_decode_select(dec), .pattern_select(pat),
        .rx_data(rx_data), .rx_clk(rx_clk));

    brs_modem_model modem_u (.rx_clk(rx_clk), .rx_data(rx_data));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk

    // read results are compared here, in the order the master noted them
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            chk({pslverr, prdata}, exp_q.pop_front());
        end
    end

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) begin
            exp_q.push_back(e);
        end
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        // a slave that never answers counts against the run
        if (pready !== 1'b1) begin
            fails++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask : rd

    task wait_rst(input logic lv, input int lim);
        n = 0;
        while (board_reset_n !== lv && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_rst

    task rng(input int lo, input int hi);
        chk(33'(n >= lo && n <= hi), 33'h1);
    endtask : rng

    task wait_nmi();
        n = 0;
        while (nmi !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_nmi

    task frame(input int p, input int tp, input int flip, input logic [1:0] d, input logic c);
        pat <= 4'(p);
        dec <= d;
        clk_sel <= c;
        repeat (4) @(posedge pclk);
        modem_u.send(TAPS[tp], 8'($urandom_range(255, 1)), flip, d == 2'd1, c);
    endtask : frame

    task close_out();
        $display("counts: %0d compares, %0d mismatches", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    initial begin
        #900_000;
        fails++;
        close_out();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, wd_en, clk_sel, dec, pat} = '0;
        {power_good, pb_n, dbg_n, nmi_en} = 4'hf;
        void'($urandom(32'hf4834ead));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        wait_rst(1'b1, HL + 40);
        rng(HL, HL + 8);
        rd(OFS_CAUSE, 32'h1);
        rd(OFS_IRQ_ENABLE, 32'h0);
        rd(OFS_JUMPERS, {23'h0, 9'h080});
        apb(1'b0, 8'hfc, 32'h0, {1'b1, 32'h0});
        rd(OFS_IRQ_CLEAR, 32'h0);
        v = 4'($urandom_range(15));
        wr(OFS_IRQ_ENABLE, {28'h0, v});
        rd(OFS_IRQ_ENABLE, {28'h0, v});
        $display("test registers done");
        wd_en <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            repeat ($urandom_range(150, 50)) @(posedge pclk);
            rd(OFS_WDOG, 32'h0);
            chk(board_reset_n, 1'b1);
        end
        wait_rst(1'b0, WL + 40);
        wd_en <= 1'b0;
        rng(WL - 5, WL + 5);
        wait_rst(1'b1, HL + 40);
        rd(OFS_CAUSE, 32'h4);
        repeat (3 * WL) @(posedge pclk);
        chk(board_reset_n, 1'b1);
        $display("test watchdog done");
        wr(OFS_IRQ_CLEAR, 32'hf);
        wr(OFS_IRQ_ENABLE, 32'h4);
        pb_n <= 1'b0;
        repeat (3) @(posedge pclk);
        pb_n <= 1'b1;
        repeat (20) @(posedge pclk);
        chk(board_reset_n, 1'b1);
        for (int i = 0; i < 2; i++) begin
            if (i == 1) begin
                dbg_n <= 1'b0;
            end else begin
                pb_n <= 1'b0;
            end
            wait_rst(1'b0, DL + 20);
            rng(DL, DL + 6);
            chk(irq, 1'b1);
            repeat (50) @(posedge pclk);
            pb_n <= 1'b1;
            dbg_n <= 1'b1;
            wait_rst(1'b1, HL + DL + 40);
            rng(HL + DL, HL + DL + 8);
            rd(OFS_CAUSE, 32'h2);
            rd(OFS_IRQ_STATUS, 32'h4);
            wr(OFS_IRQ_ENABLE, 32'h0);
            @(posedge pclk);
            chk(irq, 1'b0);
            wr(OFS_IRQ_ENABLE, 32'h4);
            @(posedge pclk);
            chk(irq, 1'b1);
            wr(OFS_IRQ_CLEAR, 32'h4);
            @(posedge pclk);
            chk(irq, 1'b0);
        end
        $display("test manual done");
        power_good <= 1'b0;
        wait_rst(1'b0, 10);
        rng(1, 6);
        repeat (30) @(posedge pclk);
        power_good <= 1'b1;
        wait_rst(1'b1, HL + 30);
        rng(HL, HL + 6);
        rd(OFS_CAUSE, 32'h1);
        rd(OFS_IRQ_STATUS, 32'h8);
        wr(OFS_IRQ_CLEAR, 32'hf);
        $display("test power done");
        // modem clock with every decoding first, then recovered timing for nrz and nrzi
        for (int p = 0; p < 14; p++) begin
            frame(p % 12, p % 12, -1, p < 12 ? 2'(p % 4) : 2'(p - 12), p < 12);
            wait_nmi();
            chk(nmi, 1'b1);
            wr(OFS_REMOTE_ACK, 32'h1);
            @(posedge pclk);
            chk(nmi, 1'b0);
        end
        frame(5, 5, 130, 2'd2, 1'b1);
        repeat (50) @(posedge pclk);
        chk(nmi, 1'b0);
        frame(3, 4, -1, 2'd2, 1'b1);
        repeat (50) @(posedge pclk);
        chk(nmi, 1'b0);
        // the remote status bit marks the detection edge, so the timeout is timed from it
        wr(OFS_IRQ_CLEAR, 32'h1);
        wr(OFS_IRQ_ENABLE, 32'h1);
        nmi_en <= 1'b0;
        fork
            frame(7, 7, -1, 2'd2, 1'b1);
            begin
                n = 0;
                while (irq !== 1'b1 && n < 4000) begin
                    @(posedge pclk);
                    n++;
                end
                chk(irq, 1'b1);
                chk(nmi, 1'b0);
                wait_rst(1'b0, RL + 20);
                rng(RL - 2, RL + 2);
            end
        join
        wait_rst(1'b1, HL + 30);
        rd(OFS_CAUSE, 32'h8);
        $display("test remote done");
        close_out();
    end
endmodule : brs_board_reset_supervisor_tb_top
